// [ptpm_board.sv]
/* Board model on the pads: pull-ups plus an optional external driver.
   Assumes pinOe is high while the port drives a pad. */
`timescale 1ns/1ps
`default_nettype none
module ptpm_board (
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] extDrive,
    input wire logic [7:0] extVal,
    output logic [7:0] pinIn
);
    // Wired-AND with pull-ups: a released pad floats high, never keeps old data
    assign pinIn = (pinOe & pinOut | ~pinOe) & (extDrive & extVal | ~extDrive);
endmodule : ptpm_board
`default_nettype wire

// [ptpm_ovr_if.sv]
/*
  Per-pin override bundle between the port top and the pin cell.
  Assumes all signals are on the port clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface ptpm_ovr_if;
    logic [7:0] ownDir;    // Peripheral owns direction
    logic [7:0] ovrOut;    // Forced output when owned
    logic [7:0] ovrData;   // Peripheral data
    logic [7:0] odSel;     // Open-drain select
    logic [7:0] analogOff; // Digital path disabled
    modport source (output ownDir, ovrOut, ovrData, odSel, analogOff);
    modport sink (input ownDir, ovrOut, ovrData, odSel, analogOff);
endinterface : ptpm_ovr_if
`default_nettype wire

// [ptpm_pin_cell.sv]
/*
  Output stage for all pins: direction, data and open-drain resolution.
  Assumes override bundle already resolved per pin by the port top.
*/
`timescale 1ns/1ps
`default_nettype none
module ptpm_pin_cell (
    input wire logic clk,
    input wire logic reset_n,
    ptpm_ovr_if.sink ovr,
    input wire logic [7:0] dirBits,
    input wire logic [7:0] latchBits,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe
);
    logic [7:0] outNext;
    logic [7:0] oeNext;
    // --------------------------------------------------------
    // Per-pin resolution
    // --------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < ptpm_pkg::PORT_WIDTH; i++) begin : g_pin
            logic drive;
            logic data;
            // Analog pins never drive; else owner picks direction, else direction bit 0 means output
            assign drive = ovr.analogOff[i] ? 1'b0 :
                ovr.ownDir[i] ? ovr.ovrOut[i] : ~dirBits[i];
            assign data = ovr.ownDir[i] ? ovr.ovrData[i] : latchBits[i];
            // Open drain only pulls low; high level released
            assign oeNext[i] = drive & ~(ovr.odSel[i] & data);
            assign outNext[i] = ovr.odSel[i] ? 1'b0 : data;
        end
    endgenerate
    // Registered pad outputs; reset leaves all pins floating inputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pinOe <= 8'h00;
            pinOut <= 8'h00;
        end else begin
            pinOe <= oeNext;
            pinOut <= outNext;
        end
    end
endmodule : ptpm_pin_cell
`default_nettype wire

// [ptpm_pkg.sv]
/*
  Constants and pin numbering for the eight-pin shared GPIO port.
  Assumes a single 20 MHz clock domain and synchronous active-low reset.
*/
`default_nettype none
package ptpm_pkg;
    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int PORT_WIDTH = 8;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic CAP2_SEL_RESET = 1'h1;
    // ------------------------------------------------------------
    // Pin positions
    // ------------------------------------------------------------
    localparam int PIN_ZERO = 0;
    localparam int PIN_ONE = 1;
    localparam int PIN_TWO = 2;
    localparam int PIN_THREE = 3;
    localparam int PIN_SIX = 6;
    localparam int PIN_SEVEN = 7;
    // Pin serving capture two when moved off pin one
    localparam int PIN_CAP2_ALT = 7;
endpackage : ptpm_pkg
`default_nettype wire

// [ptpm_port.sv]
/*
  Eight-pin shared GPIO port with peripheral overrides.
  Assumes software writes come as one-cycle strobes on the port clock and
  peripheral controls are synchronous to the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ptpm_port (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic dirWrite,
    input wire logic [7:0] dirWdata,
    input wire logic latchWrite,
    input wire logic [7:0] latchWdata,
    output logic [7:0] directionBits,
    output logic [7:0] outputLatch,
    output logic [7:0] thirdPortPins,
    input wire logic capture2PinSelect,
    input wire logic extendedMode,
    input wire logic spiOpenDrainSel,
    input wire logic pwmOneOpenDrainSel,
    input wire logic pwmTwoOpenDrainSel,
    input wire logic uartOpenDrainSel,
    input wire logic subOscEnable,
    input wire logic capOneEnable,
    input wire logic capOneData,
    input wire logic pwmOneShutdown,
    input wire logic capTwoEnable,
    input wire logic capTwoData,
    input wire logic pwmTwoShutdown,
    input wire logic spiEnable,
    input wire logic spiClockOut,
    input wire logic twowireEnable,
    input wire logic twowireClockOut,
    input wire logic uartSyncEnable,
    input wire logic uartClockMaster,
    input wire logic uartClockOut,
    input wire logic uartDataOut,
    input wire logic uartDataDrive,
    output logic capOneIn,
    output logic capTwoIn,
    output logic serialOneClockIn,
    output logic timerExtCountIn,
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    output logic capTwoSelected
);
    ptpm_ovr_if ovr ();
    logic [7:0] dir_reg;
    logic [7:0] latch_reg;
    logic [7:0] syncA_reg;
    logic [7:0] syncB_reg;
    logic [7:0] sampled;
    logic cap2Sel_reg;
    logic cap2OnOne;
    logic cap2OnAlt;
    logic [7:0] ownDir;
    logic [7:0] ovrOut;
    logic [7:0] ovrData;
    logic [7:0] odSel;
    logic [7:0] analogOff;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Direction bits never touched by overrides, so reads stay true
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dir_reg <= ptpm_pkg::DIR_RESET;
        end else if (dirWrite) begin
            dir_reg <= dirWdata;
        end
    end

    // Output latch
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            latch_reg <= ptpm_pkg::LATCH_RESET;
        end else if (latchWrite) begin
            latch_reg <= latchWdata;
        end
    end

    // Pin-select strap caught at each synchronous reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cap2Sel_reg <= capture2PinSelect;
        end
    end

    assign directionBits = dir_reg;
    assign outputLatch = latch_reg;

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            syncA_reg <= 8'h00;
            syncB_reg <= 8'h00;
        end else begin
            syncA_reg <= pinIn;
            syncB_reg <= syncA_reg;
        end
    end

    // Analog oscillator pins read as zero
    assign sampled = syncB_reg & ~analogOff;
    // Port read returns pin levels
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            thirdPortPins <= 8'h00;
        end else begin
            thirdPortPins <= sampled;
        end
    end

    // ------------------------------------------------------------
    // Capture two placement
    // ------------------------------------------------------------
    // Alternate placement only legal in extended mode of large package
    assign cap2OnOne = cap2Sel_reg | ~extendedMode;
    assign cap2OnAlt = ~cap2OnOne;
    assign capTwoSelected = cap2OnOne;

    // ------------------------------------------------------------
    // Override resolution
    // ------------------------------------------------------------
    // Peripheral ownership; pins not listed fall back to port control
    always_comb begin
        ownDir = 8'h00;
        ovrOut = 8'h00;
        ovrData = 8'h00;
        odSel = 8'h00;
        analogOff = 8'h00;
        // Sub oscillator turns pins 0 and 1 analog
        if (subOscEnable) begin
            analogOff[ptpm_pkg::PIN_ZERO] = 1'b1;
            analogOff[ptpm_pkg::PIN_ONE] = 1'b1;
        end
        // Capture one: direction bit picks output or capture input
        if (capOneEnable) begin
            ownDir[ptpm_pkg::PIN_TWO] = 1'b1;
            ovrOut[ptpm_pkg::PIN_TWO] = ~dir_reg[ptpm_pkg::PIN_TWO] & ~pwmOneShutdown;
            ovrData[ptpm_pkg::PIN_TWO] = capOneData;
            odSel[ptpm_pkg::PIN_TWO] = pwmOneOpenDrainSel;
        end
        // Capture two on pin one or its alternate pin
        if (capTwoEnable && cap2OnOne) begin
            ownDir[ptpm_pkg::PIN_ONE] = 1'b1;
            ovrOut[ptpm_pkg::PIN_ONE] = ~dir_reg[ptpm_pkg::PIN_ONE] & ~pwmTwoShutdown;
            ovrData[ptpm_pkg::PIN_ONE] = capTwoData;
            odSel[ptpm_pkg::PIN_ONE] = pwmTwoOpenDrainSel;
        end
        if (capTwoEnable && cap2OnAlt) begin
            ownDir[ptpm_pkg::PIN_CAP2_ALT] = 1'b1;
            ovrOut[ptpm_pkg::PIN_CAP2_ALT] = ~dir_reg[ptpm_pkg::PIN_CAP2_ALT]
                & ~pwmTwoShutdown;
            ovrData[ptpm_pkg::PIN_CAP2_ALT] = capTwoData;
            odSel[ptpm_pkg::PIN_CAP2_ALT] = pwmTwoOpenDrainSel;
        end
        // Serial clock: SPI follows direction bit, two-wire drives low only while its clock output is low
        if (twowireEnable) begin
            ownDir[ptpm_pkg::PIN_THREE] = 1'b1;
            ovrOut[ptpm_pkg::PIN_THREE] = ~twowireClockOut;
            ovrData[ptpm_pkg::PIN_THREE] = 1'b0;
        end else if (spiEnable) begin
            ownDir[ptpm_pkg::PIN_THREE] = 1'b1;
            ovrOut[ptpm_pkg::PIN_THREE] = ~dir_reg[ptpm_pkg::PIN_THREE];
            ovrData[ptpm_pkg::PIN_THREE] = spiClockOut;
            odSel[ptpm_pkg::PIN_THREE] = spiOpenDrainSel;
        end
        // Synchronous UART: clock on pin six, data on pin seven unless capture two holds its alternate pin
        if (uartSyncEnable) begin
            ownDir[ptpm_pkg::PIN_SIX] = 1'b1;
            ovrOut[ptpm_pkg::PIN_SIX] = uartClockMaster;
            ovrData[ptpm_pkg::PIN_SIX] = uartClockOut;
            odSel[ptpm_pkg::PIN_SIX] = uartOpenDrainSel;
            if (!(capTwoEnable && cap2OnAlt)) begin
                ownDir[ptpm_pkg::PIN_SEVEN] = 1'b1;
                ovrOut[ptpm_pkg::PIN_SEVEN] = uartDataDrive;
                ovrData[ptpm_pkg::PIN_SEVEN] = uartDataOut;
                odSel[ptpm_pkg::PIN_SEVEN] = uartOpenDrainSel;
            end
        end
    end

    assign ovr.ownDir = ownDir;
    assign ovr.ovrOut = ovrOut;
    assign ovr.ovrData = ovrData;
    assign ovr.odSel = odSel;
    assign ovr.analogOff = analogOff;

    // ------------------------------------------------------------
    // Peripheral inputs, taken from synchronised pins
    // ------------------------------------------------------------
    assign capOneIn = sampled[ptpm_pkg::PIN_TWO];
    assign capTwoIn = cap2OnOne ? sampled[ptpm_pkg::PIN_ONE]
        : sampled[ptpm_pkg::PIN_CAP2_ALT];
    assign serialOneClockIn = sampled[ptpm_pkg::PIN_THREE];
    assign timerExtCountIn = sampled[ptpm_pkg::PIN_ZERO];

    // ------------------------------------------------------------
    // Pad stage
    // ------------------------------------------------------------
    ptpm_pin_cell u_ptpm_pin_cell (
        .clk(clk),
        .reset_n(reset_n),
        .ovr(ovr),
        .dirBits(dir_reg),
        .latchBits(latch_reg),
        .pinOut(pinOut),
        .pinOe(pinOe)
    );
endmodule : ptpm_port
`default_nettype wire

// [ptpm_port_test.sv]
/* Self-checking bench for the shared port, one task per scenario.
   Assumes the board model on the pads and a 20 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module ptpm_port_test;
    logic clk, reset_n, dirWrite, latchWrite, capture2PinSelect, extendedMode;
    logic spiOpenDrainSel, pwmOneOpenDrainSel, pwmTwoOpenDrainSel, uartOpenDrainSel;
    logic subOscEnable, capOneEnable, capOneData, pwmOneShutdown, capTwoEnable, capTwoData;
    logic pwmTwoShutdown, spiEnable, spiClockOut, twowireEnable, twowireClockOut;
    logic uartSyncEnable, uartClockMaster, uartClockOut, uartDataOut, uartDataDrive;
    logic capOneIn, capTwoIn, serialOneClockIn, timerExtCountIn, capTwoSelected;
    logic [7:0] dirWdata, latchWdata, directionBits, outputLatch, thirdPortPins;
    logic [7:0] pinIn, pinOut, pinOe, extDrive, extVal;
    int nErrors = 0;
    int compares = 0;
    ptpm_port u_ptpm_port (.*);
    ptpm_board u_ptpm_board (.*);
    // ------------------------------------------------------------
    // Clock and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Checks run on falling edges so the rising-edge updates have landed
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask : settle
    task automatic wr(input logic isDir, input logic [7:0] v);
        @(posedge clk);
        {dirWrite, latchWrite, dirWdata, latchWdata} <= {isDir, !isDir, v, v};
        @(posedge clk);
        {dirWrite, latchWrite} <= 2'h0;
        settle(5);
    endtask : wr
    task automatic doRst(input logic sel);
        @(posedge clk);
        {reset_n, capture2PinSelect} <= {1'b0, sel};
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        settle(1);
    endtask : doRst
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_gpio;
        wr(1'b0, 8'ha5);
        wr(1'b1, 8'h00);
        chk(pinOe, 8'hff);
        chk(thirdPortPins, 8'ha5);
        @(posedge clk);
        {extDrive, extVal} <= 16'hf060;
        wr(1'b1, 8'hf0);
        chk(thirdPortPins, 8'h65);
        chk(directionBits, 8'hf0);
        $display("gpio test done");
    endtask : t_gpio
    task automatic t_sclk;
        wr(1'b1, 8'hf7);
        @(posedge clk);
        {spiEnable, spiClockOut, extDrive} <= 10'h300;
        settle(3);
        chk(pinOe & pinOut, 8'h08);
        @(posedge clk);
        spiOpenDrainSel <= 1'b1;
        settle(3);
        chk(pinOe, 8'h00);
        wr(1'b1, 8'hff);
        @(posedge clk);
        {spiEnable, spiOpenDrainSel, twowireEnable, twowireClockOut} <= 4'h2;
        settle(3);
        chk(pinOe, 8'h08);
        chk(pinOut & 8'h08, 8'h00);
        chk(directionBits, 8'hff);
        @(posedge clk);
        {twowireClockOut, extDrive, extVal} <= 17'h10800;
        settle(5);
        chk({6'h00, pinOe[3], serialOneClockIn}, 8'h00);
        // Released clock must be sensed high again through the pull-up
        @(posedge clk);
        extDrive <= 8'h00;
        settle(4);
        chk({7'h00, serialOneClockIn}, 8'h01);
        @(posedge clk);
        twowireEnable <= 1'b0;
        $display("serial clock test done");
    endtask : t_sclk
    task automatic t_capone;
        wr(1'b1, 8'hfb);
        @(posedge clk);
        {capOneEnable, capOneData} <= 2'h3;
        settle(3);
        chk(pinOe & pinOut, 8'h04);
        @(posedge clk);
        pwmOneShutdown <= 1'b1;
        settle(3);
        chk(pinOe, 8'h00);
        @(posedge clk);
        {pwmOneShutdown, pwmOneOpenDrainSel, capOneData} <= 3'h2;
        settle(3);
        chk({6'h00, pinOe[2], pinOut[2]}, 8'h02);
        @(posedge clk);
        {pwmOneOpenDrainSel, extDrive, extVal} <= 17'h00404;
        wr(1'b1, 8'hff);
        chk({7'h00, capOneIn}, 8'h01);
        @(posedge clk);
        {capOneEnable, extDrive} <= 9'h000;
        $display("capture one test done");
    endtask : t_capone
    task automatic t_subosc;
        wr(1'b1, 8'h00);
        @(posedge clk);
        {subOscEnable, extDrive, extVal} <= 17'h10303;
        settle(5);
        chk(pinOe, 8'hfc);
        chk(thirdPortPins & 8'h03, 8'h00);
        chk({7'h00, timerExtCountIn}, 8'h00);
        @(posedge clk);
        {subOscEnable, extDrive} <= 9'h000;
        $display("oscillator test done");
    endtask : t_subosc
    // Strap is only sampled in reset, so each pin choice costs a reset
    task automatic t_captwo;
        doRst(1'b0);
        chk(directionBits, 8'hff);
        chk(pinOe, 8'h00);
        chk({7'h00, capTwoSelected}, 8'h00);
        wr(1'b1, 8'h00);
        @(posedge clk);
        {capTwoEnable, capTwoData} <= 2'h3;
        settle(3);
        chk(pinOut & 8'h82, 8'h80);
        settle(2);
        chk({7'h00, capTwoIn}, 8'h01);
        // Outside extended mode the alternate pin is never used
        @(posedge clk);
        extendedMode <= 1'b0;
        settle(1);
        chk({7'h00, capTwoSelected}, 8'h01);
        @(posedge clk);
        extendedMode <= 1'b1;
        doRst(1'b1);
        chk({7'h00, capTwoSelected}, 8'h01);
        wr(1'b1, 8'h00);
        chk(pinOut & 8'h82, 8'h02);
        @(posedge clk);
        pwmTwoShutdown <= 1'b1;
        settle(3);
        chk(pinOe & 8'h82, 8'h80);
        @(posedge clk);
        {uartSyncEnable, uartDataDrive, uartDataOut, uartOpenDrainSel} <= 4'hf;
        settle(3);
        chk(pinOe & 8'hc0, 8'h00);
        $display("capture two test done");
    endtask : t_captwo
    task automatic final_report;
        $display("compares %0d errors %0d", compares, nErrors);
        if (nErrors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        {reset_n, dirWrite, latchWrite, dirWdata, latchWdata, extDrive, extVal} = '0;
        {spiOpenDrainSel, pwmOneOpenDrainSel, pwmTwoOpenDrainSel, uartOpenDrainSel} = '0;
        {subOscEnable, capOneEnable, capOneData, pwmOneShutdown, capTwoEnable, capTwoData} = '0;
        {pwmTwoShutdown, spiEnable, spiClockOut, twowireEnable, twowireClockOut} = '0;
        {uartSyncEnable, uartClockMaster, uartClockOut, uartDataOut, uartDataDrive} = '0;
        {capture2PinSelect, extendedMode} = 2'h3;
        doRst(1'b1);
        t_gpio();
        t_sclk();
        t_capone();
        t_subosc();
        t_captwo();
        final_report();
    end
endmodule : ptpm_port_test
`default_nettype wire

// [ptpm_props.sv]
/* Checker for the shared port: register write-back, pin drive and overrides.
   Assumes one clock domain with a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module ptpm_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic dirWrite,
    input wire logic [7:0] dirWdata,
    input wire logic latchWrite,
    input wire logic [7:0] latchWdata,
    input wire logic [7:0] directionBits,
    input wire logic [7:0] outputLatch,
    input wire logic [7:0] thirdPortPins,
    input wire logic spiOpenDrainSel,
    input wire logic pwmOneOpenDrainSel,
    input wire logic subOscEnable,
    input wire logic capOneEnable,
    input wire logic capOneData,
    input wire logic pwmOneShutdown,
    input wire logic spiEnable,
    input wire logic spiClockOut,
    input wire logic twowireEnable,
    input wire logic twowireClockOut,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Overrides are judged after two steady cycles (four for the sub oscillator), so pin flops have caught up
    property p_resetVals;
        $rose(reset_n) |-> directionBits == 8'hff && outputLatch == 8'h00 && pinOe == 8'h00;
    endproperty
    a_resetVals: assert property (p_resetVals) else $error("reset state wrong");
    property p_dirWr; dirWrite |=> directionBits == $past(dirWdata); endproperty
    a_dirWr: assert property (p_dirWr) else $error("direction readback wrong");
    property p_latWr; latchWrite |=> outputLatch == $past(latchWdata); endproperty
    a_latWr: assert property (p_latWr) else $error("latch write lost");
    // Pins four and five carry no peripheral here, so they are plain GPIO
    property p_plain;
        1 |=> pinOe[4] == !$past(directionBits[4]) && (!pinOe[4] || pinOut[4] == $past(outputLatch[4]));
    endproperty
    a_plain: assert property (p_plain) else $error("plain pin drive wrong");
    property p_subOsc; subOscEnable[*4] |-> pinOe[1:0] == 2'h0 && thirdPortPins[1:0] == 2'h0; endproperty
    a_subOsc: assert property (p_subOsc) else $error("oscillator pins not analog");
    property p_capOut;
        (capOneEnable && !pwmOneShutdown && !pwmOneOpenDrainSel && !directionBits[2])[*2]
            |-> pinOe[2] && pinOut[2] == $past(capOneData);
    endproperty
    a_capOut: assert property (p_capOut) else $error("capture one output wrong");
    property p_od;
        (capOneEnable && pwmOneOpenDrainSel && !pwmOneShutdown && !directionBits[2])[*2]
            |-> !pinOut[2] && pinOe[2] == !$past(capOneData);
    endproperty
    a_od: assert property (p_od) else $error("open-drain drive wrong");
    property p_spi;
        (spiEnable && !twowireEnable && !spiOpenDrainSel && !directionBits[3])[*2]
            |-> pinOe[3] && pinOut[3] == $past(spiClockOut);
    endproperty
    a_spi: assert property (p_spi) else $error("serial clock output wrong");
    property p_twc; twowireEnable[*2] |-> !pinOut[3] && pinOe[3] == !$past(twowireClockOut); endproperty
    a_twc: assert property (p_twc) else $error("two-wire clock drive wrong");
    c_shut: cover property (capOneEnable && pwmOneShutdown);
    c_twc: cover property (twowireEnable && !twowireClockOut);
    c_osc: cover property (subOscEnable[*4]);
endmodule : ptpm_props
bind ptpm_port ptpm_props u_ptpm_props (.*);
`default_nettype wire
